// ===== common/bsw_pkg.sv
// ============================================================
// Shared constants for the secondary window register bank
// ============================================================
package bsw_pkg;

  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets, byte addresses of aligned words
  localparam logic [ADDR_W-1:0] BUS_LAT_OFS  = 8'h18;  // Bus numbers and latency byte
  localparam logic [ADDR_W-1:0] IO_STAT_OFS  = 8'h1c;  // I/O base, I/O limit, status
  localparam logic [ADDR_W-1:0] MEM_WIN_OFS  = 8'h20;  // Memory base and limit
  localparam logic [ADDR_W-1:0] IO_UPPER_OFS = 8'h30;  // I/O base and limit upper halves
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h40;  // Sticky event status, read clears
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h44;  // Interrupt mask

  // Latency byte, hardwired
  localparam int         LAT_LSB     = 24;
  localparam logic [7:0] LAT_VAL     = 8'h00;

  // I/O window byte fields
  localparam int         NIB_W          = 4;
  localparam logic [3:0] IO_CAP_VAL     = 4'h1;   // 32-bit I/O addressing indicator
  localparam logic [3:0] IO_NIB_RST     = 4'h0;
  localparam int         IO_BASE_CAP_LSB  = 0;
  localparam int         IO_BASE_ADDR_LSB = 4;
  localparam int         IO_LIM_CAP_LSB   = 8;
  localparam int         IO_LIM_ADDR_LSB  = 12;
  localparam logic [11:0] IO_LOW_ZERO   = 12'h000;
  localparam logic [11:0] IO_LOW_ONES   = 12'hfff;

  // I/O upper halves
  localparam int          UP_W           = 16;
  localparam int          IO_UP_BASE_LSB = 0;
  localparam int          IO_UP_LIM_LSB  = 16;
  localparam logic [15:0] IO_UP_RST      = 16'h0000;

  // Memory window fields
  localparam int          MEM_W         = 12;
  localparam int          MEM_BASE_LSB  = 4;
  localparam int          MEM_LIM_LSB   = 20;
  localparam logic [11:0] MEM_RST       = 12'h000;
  localparam logic [19:0] MEM_LOW_ZERO  = 20'h00000;
  localparam logic [19:0] MEM_LOW_ONES  = 20'hfffff;

  // Secondary status bit positions
  localparam int ST_PARITY    = 24;
  localparam int ST_SIG_ABORT = 27;
  localparam int ST_RCV_ABORT = 28;
  localparam int ST_RCV_UR    = 29;
  localparam int ST_SYS_ERR   = 30;
  localparam int ST_POISON    = 31;

  // Event vector indices, shared by the status and interrupt banks
  localparam int EV_PARITY    = 0;
  localparam int EV_SIG_ABORT = 1;
  localparam int EV_RCV_ABORT = 2;
  localparam int EV_RCV_UR    = 3;
  localparam int EV_SYS_ERR   = 4;
  localparam int EV_POISON    = 5;
  localparam int EV_W         = 6;

  typedef logic [EV_W-1:0]   ev_vec_t;
  typedef logic [DATA_W-1:0] word_t;

  localparam ev_vec_t EV_ZERO = 6'h00;

endpackage

// ===== common/win_cfg_if.sv
`timescale 1ns/1ns
// ============================================================
// Window settings and transaction probe between bank and matcher
// ============================================================
interface win_cfg_if;
  logic [31:0] io_lo;      // Assembled lowest forwarded I/O address
  logic [31:0] io_hi;      // Assembled highest forwarded I/O address
  logic [31:0] mem_lo;     // Assembled lowest forwarded memory address
  logic [31:0] mem_hi;     // Assembled highest forwarded memory address
  logic        txn_valid;  // Transaction presented for a decision
  logic        txn_is_io;  // High for I/O, low for memory
  logic [31:0] txn_addr;   // Transaction address
  logic        fwd_hit;    // Registered forward decision

  modport regs  (output io_lo, io_hi, mem_lo, mem_hi, txn_valid, txn_is_io, txn_addr, input fwd_hit);
  modport match (input io_lo, io_hi, mem_lo, mem_hi, txn_valid, txn_is_io, txn_addr, output fwd_hit);
endinterface

// ===== verilog/sticky_flag_bank.sv
`timescale 1ns/1ns
// ============================================================
// Bank of sticky flags: set wins over clear
// ============================================================
module sticky_flag_bank
  import bsw_pkg::*;
(
  input  wire logic    clk_sys,
  input  wire logic    sys_rst,
  input  wire ev_vec_t set_vec,   // Hardware set requests
  input  wire ev_vec_t clr_vec,   // Software clear requests
  output ev_vec_t      flags      // Current flag values
);

  ev_vec_t flags_r;    // Flag state
  ev_vec_t flags_nxt;  // Next flag state

  // A set in the same cycle as a clear survives so no event is lost
  always_comb begin
    flags_nxt = (flags_r & ~clr_vec) | set_vec;
  end

  // Flags start cleared
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flags_r <= EV_ZERO;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;

endmodule

// ===== verilog/window_match.sv
`timescale 1ns/1ns
// ============================================================
// Forward decision for I/O and memory windows
// ============================================================
module window_match
  import bsw_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  win_cfg_if.match  win
);

  logic hit_r;    // Registered decision
  logic hit_nxt;  // Next decision

  // Inclusive range test, used for both windows
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Pick the window that matches the transaction kind
  always_comb begin
    hit_nxt = 1'b0;
    if (win.txn_valid) begin
      if (win.txn_is_io) begin
        hit_nxt = in_range(win.txn_addr, win.io_lo, win.io_hi);
      end else begin
        hit_nxt = in_range(win.txn_addr, win.mem_lo, win.mem_hi);
      end
    end
  end

  // Decision stands one cycle after the probe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
    end
  end

  assign win.fwd_hit = hit_r;

endmodule

// ===== verilog/bridge_secondary_window_regs.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
module bridge_secondary_window_regs
  import bsw_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // ============================================================
  // Register port
  // ============================================================
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata,
  // ============================================================
  // Packet logic events, one-cycle pulses, and two level report enables
  // ============================================================
  input  wire logic              parity_err_seen,
  input  wire logic              parity_err_resp_enable,
  input  wire logic              cpl_abort_sent,
  input  wire logic              cpl_abort_rcvd,
  input  wire logic              unsup_req_rcvd,
  input  wire logic              err_msg_sent,
  input  wire logic              system_error_report_enable,
  input  wire logic              poisoned_rcvd,
  // ============================================================
  // Forward decision probe
  // ============================================================
  input  wire logic              txn_valid,
  input  wire logic              txn_is_io,
  input  wire logic [31:0]       txn_addr,
  output logic                   fwd_hit,
  // ============================================================
  // Interrupt
  // ============================================================
  output logic                   irq
);

  // ============================================================
  // Address decode
  // ============================================================

  // Match of a strobe against one register offset
  // The whole offset is compared, so no word answers through an alias
  function automatic logic sel(input logic stb, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    sel = stb && (a == ofs);
  endfunction

  logic wr_io_stat;   // Write to I/O and status word
  logic wr_mem_win;   // Write to memory window word
  logic wr_io_upper;  // Write to I/O upper halves
  logic wr_irq_mask;  // Write to interrupt mask
  logic rd_irq_stat;  // Read of interrupt status, clears it

  assign wr_io_stat  = sel(reg_wr, reg_addr, IO_STAT_OFS);
  assign wr_mem_win  = sel(reg_wr, reg_addr, MEM_WIN_OFS);
  assign wr_io_upper = sel(reg_wr, reg_addr, IO_UPPER_OFS);
  assign wr_irq_mask = sel(reg_wr, reg_addr, IRQ_MASK_OFS);
  assign rd_irq_stat = sel(reg_rd, reg_addr, IRQ_STAT_OFS);
  // Writes to read-only or unmapped offsets decode to nothing and are dropped

  // ============================================================
  // Writable window fields
  // ============================================================
  logic [NIB_W-1:0] io_base_nib_r;    // I/O base address bits 15:12
  logic [NIB_W-1:0] io_base_nib_nxt;
  logic [NIB_W-1:0] io_lim_nib_r;     // I/O limit address bits 15:12
  logic [NIB_W-1:0] io_lim_nib_nxt;
  logic [UP_W-1:0]  io_base_up_r;     // I/O base address bits 31:16
  logic [UP_W-1:0]  io_base_up_nxt;
  logic [UP_W-1:0]  io_lim_up_r;      // I/O limit address bits 31:16
  logic [UP_W-1:0]  io_lim_up_nxt;
  logic [MEM_W-1:0] mem_base_r;       // Memory base address bits 31:20
  logic [MEM_W-1:0] mem_base_nxt;
  logic [MEM_W-1:0] mem_lim_r;        // Memory limit address bits 31:20
  logic [MEM_W-1:0] mem_lim_nxt;
  ev_vec_t          irq_mask_r;       // Interrupt enables, one per event
  ev_vec_t          irq_mask_nxt;

  // Only the writable fields take write data; hardwired bits are never stored
  // Hold values by default, load on a matching write
  // The I/O nibbles share a word with the flags: software clearing a flag
  // must write back the nibbles it read, or the I/O window moves
  always_comb begin
    io_base_nib_nxt = io_base_nib_r;
    io_lim_nib_nxt  = io_lim_nib_r;
    io_base_up_nxt  = io_base_up_r;
    io_lim_up_nxt   = io_lim_up_r;
    mem_base_nxt    = mem_base_r;
    mem_lim_nxt     = mem_lim_r;
    irq_mask_nxt    = irq_mask_r;
    if (wr_io_stat) begin
      io_base_nib_nxt = reg_wdata[IO_BASE_ADDR_LSB +: NIB_W];
      io_lim_nib_nxt  = reg_wdata[IO_LIM_ADDR_LSB +: NIB_W];
    end
    if (wr_mem_win) begin
      mem_base_nxt = reg_wdata[MEM_BASE_LSB +: MEM_W];
      mem_lim_nxt  = reg_wdata[MEM_LIM_LSB +: MEM_W];
    end
    if (wr_io_upper) begin
      io_base_up_nxt = reg_wdata[IO_UP_BASE_LSB +: UP_W];
      io_lim_up_nxt  = reg_wdata[IO_UP_LIM_LSB +: UP_W];
    end
    if (wr_irq_mask) begin
      irq_mask_nxt = reg_wdata[EV_W-1:0];  // Bits above the event count are dropped
    end
  end

  // Window fields come up at zero, so the I/O window spans 0 to 0xfff and the memory window 0 to 0xfffff
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      io_base_nib_r <= IO_NIB_RST;
      io_lim_nib_r  <= IO_NIB_RST;
      io_base_up_r  <= IO_UP_RST;
      io_lim_up_r   <= IO_UP_RST;
      mem_base_r    <= MEM_RST;
      mem_lim_r     <= MEM_RST;
      irq_mask_r    <= EV_ZERO;
    end else begin
      io_base_nib_r <= io_base_nib_nxt;
      io_lim_nib_r  <= io_lim_nib_nxt;
      io_base_up_r  <= io_base_up_nxt;
      io_lim_up_r   <= io_lim_up_nxt;
      mem_base_r    <= mem_base_nxt;
      mem_lim_r     <= mem_lim_nxt;
      irq_mask_r    <= irq_mask_nxt;
    end
  end

  // ============================================================
  // Event qualification
  // ============================================================
  ev_vec_t ev_set;    // Qualified events this cycle
  ev_vec_t st_clr;    // Write-one clears for the status bank
  ev_vec_t st_flags;  // Secondary status flags
  ev_vec_t irq_clr;   // Read clear for the interrupt bank
  ev_vec_t irq_flags; // Sticky interrupt status

  // Gated events cannot set their flag while their enable is low
  // Pulses are taken as levels, so a held input sets again every cycle
  always_comb begin
    ev_set               = EV_ZERO;
    ev_set[EV_PARITY]    = parity_err_seen && parity_err_resp_enable;
    ev_set[EV_SIG_ABORT] = cpl_abort_sent;
    ev_set[EV_RCV_ABORT] = cpl_abort_rcvd;
    ev_set[EV_RCV_UR]    = unsup_req_rcvd;
    ev_set[EV_SYS_ERR]   = err_msg_sent && system_error_report_enable;
    ev_set[EV_POISON]    = poisoned_rcvd;
  end

  // Only the write_one_clear bits listen to software; the abort flags are read only
  always_comb begin
    st_clr = EV_ZERO;
    if (wr_io_stat) begin
      st_clr[EV_PARITY]  = reg_wdata[ST_PARITY];
      st_clr[EV_SYS_ERR] = reg_wdata[ST_SYS_ERR];
      st_clr[EV_POISON]  = reg_wdata[ST_POISON];
    end
  end

  // A read of the interrupt status clears all of it
  always_comb begin
    irq_clr = rd_irq_stat ? {EV_W{1'b1}} : EV_ZERO;
  end

  // ============================================================
  // Flag banks and interrupt
  // ============================================================
  // Secondary status flags; an event meeting a clear stays set
  sticky_flag_bank u_status (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .set_vec (ev_set),
    .clr_vec (st_clr),
    .flags   (st_flags)
  );

  // Interrupt status flags, same layout as the event vector
  // Any read clears all bits, masked ones too; the read returns them first
  sticky_flag_bank u_irq (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .set_vec (ev_set),
    .clr_vec (irq_clr),
    .flags   (irq_flags)
  );

  // Level interrupt while any unmasked flag stands
  // Combinational, so the line drops in the cycle after the clearing read
  assign irq = |(irq_flags & irq_mask_r);

  // ============================================================
  // Window assembly and forward decision
  // ============================================================
  win_cfg_if win ();

  // Low bits are implied: zeros below a base, ones below a limit
  // Bounds are compared as full 32-bit values, upper halves included
  assign win.io_lo     = {io_base_up_r, io_base_nib_r, IO_LOW_ZERO};
  assign win.io_hi     = {io_lim_up_r, io_lim_nib_r, IO_LOW_ONES};
  assign win.mem_lo    = {mem_base_r, MEM_LOW_ZERO};
  assign win.mem_hi    = {mem_lim_r, MEM_LOW_ONES};
  assign win.txn_valid = txn_valid;
  assign win.txn_is_io = txn_is_io;
  assign win.txn_addr  = txn_addr;

  // A base above its limit gives an empty window, which simply never hits
  // The decision is registered, so it answers one cycle after the probe
  window_match u_match (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .win     (win.match)
  );

  assign fwd_hit = win.fwd_hit;

  // ============================================================
  // Read path
  // ============================================================
  word_t rd_word;    // Word selected by the read address
  word_t rdata_r;    // Registered read data
  word_t rdata_nxt;

  // Assemble the addressed word; unlisted bits stay zero
  always_comb begin
    rd_word = '0;  // Hardwired and reserved bits stay zero
    case (reg_addr)
      BUS_LAT_OFS: begin
        rd_word[LAT_LSB +: $bits(LAT_VAL)] = LAT_VAL;
      end
      IO_STAT_OFS: begin
        rd_word[IO_BASE_CAP_LSB +: NIB_W]  = IO_CAP_VAL;
        rd_word[IO_BASE_ADDR_LSB +: NIB_W] = io_base_nib_r;
        rd_word[IO_LIM_CAP_LSB +: NIB_W]   = IO_CAP_VAL;
        rd_word[IO_LIM_ADDR_LSB +: NIB_W]  = io_lim_nib_r;
        // Speed, fast back-to-back and select_timing_field bits read zero
        // Reserved bits 20:16 and 22 read zero as well
        rd_word[ST_PARITY]    = st_flags[EV_PARITY];
        rd_word[ST_SIG_ABORT] = st_flags[EV_SIG_ABORT];
        rd_word[ST_RCV_ABORT] = st_flags[EV_RCV_ABORT];
        rd_word[ST_RCV_UR]    = st_flags[EV_RCV_UR];
        rd_word[ST_SYS_ERR]   = st_flags[EV_SYS_ERR];
        rd_word[ST_POISON]    = st_flags[EV_POISON];
      end
      MEM_WIN_OFS: begin
        // Bits 3:0 and 19:16 read zero
        rd_word[MEM_BASE_LSB +: MEM_W] = mem_base_r;
        rd_word[MEM_LIM_LSB +: MEM_W]  = mem_lim_r;
      end
      IO_UPPER_OFS: begin
        rd_word[IO_UP_BASE_LSB +: UP_W] = io_base_up_r;
        rd_word[IO_UP_LIM_LSB +: UP_W]  = io_lim_up_r;
      end
      IRQ_STAT_OFS: begin
        rd_word[EV_W-1:0] = irq_flags;
      end
      IRQ_MASK_OFS: begin
        rd_word[EV_W-1:0] = irq_mask_r;
      end
      default: begin
        // Unmapped offsets read as zero
        rd_word = '0;
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  // Gating by the strobe keeps an idle bus at zero instead of stale data
  always_comb begin
    rdata_nxt = reg_rd ? rd_word : '0;
  end

  // Read data register
  // The interrupt status word is captured here before its clear lands
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

endmodule

// ===== tb/packet_side_model.sv
`timescale 1ns/1ns
// ============================================================
// Secondary-side packet logic: turns bench requests into event pulses
// ============================================================
module packet_side_model
  import bsw_pkg::*;
(
  input  wire ev_vec_t fire,                        // One-hot event request, one cycle
  input  wire logic    gate_on,                     // Level for both report enables
  output logic         parity_err_seen,
  output logic         parity_err_resp_enable,
  output logic         cpl_abort_sent,
  output logic         cpl_abort_rcvd,
  output logic         unsup_req_rcvd,
  output logic         err_msg_sent,
  output logic         system_error_report_enable,
  output logic         poisoned_rcvd
);
  // Pulses follow the request with no delay, so they change just after an edge
  assign parity_err_seen            = fire[EV_PARITY];
  assign cpl_abort_sent             = fire[EV_SIG_ABORT];
  assign cpl_abort_rcvd             = fire[EV_RCV_ABORT];
  assign unsup_req_rcvd             = fire[EV_RCV_UR];
  assign err_msg_sent               = fire[EV_SYS_ERR];
  assign poisoned_rcvd              = fire[EV_POISON];
  // One level for both gates keeps the gated cases paired
  assign parity_err_resp_enable     = gate_on;
  assign system_error_report_enable = gate_on;
endmodule

// ===== tb/bridge_secondary_window_regs_monitor.sv
`timescale 1ns/1ns
// ============================================================
// Port-level checks on the secondary window bank
// ============================================================
module bsw_checker
  import bsw_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              parity_err_seen,
  input wire logic              parity_err_resp_enable,
  input wire logic              cpl_abort_sent,
  input wire logic              cpl_abort_rcvd,
  input wire logic              unsup_req_rcvd,
  input wire logic              err_msg_sent,
  input wire logic              system_error_report_enable,
  input wire logic              poisoned_rcvd,
  input wire logic              txn_valid,
  input wire logic              fwd_hit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Status word read strobe
  sequence s_stat_rd;
    reg_rd && reg_addr == IO_STAT_OFS;
  endsequence
  // Read two cycles after an event, no write in between that could clear it
  sequence s_late_rd;
    !reg_wr ##1 s_stat_rd;
  endsequence
  property p_lat;  reg_rd && reg_addr == BUS_LAT_OFS |=> reg_rdata == 32'h0000_0000; endproperty
  property p_cap;  s_stat_rd |=> reg_rdata[3:0] == 4'h1 && reg_rdata[11:8] == 4'h1; endproperty
  property p_hard; s_stat_rd |=> reg_rdata[21] == 1'b0 && reg_rdata[23] == 1'b0 && reg_rdata[26:25] == 2'h0; endproperty
  property p_rsvd; s_stat_rd |=> reg_rdata[20:16] == 5'h00 && reg_rdata[22] == 1'b0; endproperty
  property p_mrsv; reg_rd && reg_addr == MEM_WIN_OFS |=> reg_rdata[3:0] == 4'h0 && reg_rdata[19:16] == 4'h0; endproperty
  property p_par;  parity_err_seen && parity_err_resp_enable ##1 s_late_rd |=> reg_rdata[ST_PARITY]; endproperty
  property p_sab;  cpl_abort_sent ##1 s_late_rd |=> reg_rdata[ST_SIG_ABORT]; endproperty
  property p_rab;  cpl_abort_rcvd ##1 s_late_rd |=> reg_rdata[ST_RCV_ABORT]; endproperty
  property p_rur;  unsup_req_rcvd ##1 s_late_rd |=> reg_rdata[ST_RCV_UR]; endproperty
  property p_serr; err_msg_sent && system_error_report_enable ##1 s_late_rd |=> reg_rdata[ST_SYS_ERR]; endproperty
  property p_pois; poisoned_rcvd ##1 s_late_rd |=> reg_rdata[ST_POISON]; endproperty
  property p_idle; !txn_valid |=> !fwd_hit; endproperty
  a_lat:  assert property (p_lat)  else $error("latency byte not zero");
  a_cap:  assert property (p_cap)  else $error("io capability nibble wrong");
  a_hard: assert property (p_hard) else $error("hardwired status bit set");
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  a_mrsv: assert property (p_mrsv) else $error("reserved memory bits set");
  a_par:  assert property (p_par)  else $error("parity flag missing");
  a_sab:  assert property (p_sab)  else $error("abort sent flag missing");
  a_rab:  assert property (p_rab)  else $error("abort received flag missing");
  a_rur:  assert property (p_rur)  else $error("unsupported flag missing");
  a_serr: assert property (p_serr) else $error("error message flag missing");
  a_pois: assert property (p_pois) else $error("poison flag missing");
  a_idle: assert property (p_idle) else $error("hit without probe");
endmodule
bind bridge_secondary_window_regs bsw_checker u_chk (.clk_sys, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata, .parity_err_seen, .parity_err_resp_enable, .cpl_abort_sent, .cpl_abort_rcvd, .unsup_req_rcvd,
  .err_msg_sent, .system_error_report_enable, .poisoned_rcvd, .txn_valid, .fwd_hit);

// ===== tb/testbench.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("BAD %0t mismatch %h %h", $time, (a), (b)); end end
// ============================================================
// Self-checking bench for the secondary window bank
// ============================================================
module testbench;
  import bsw_pkg::*;
  logic              clk_sys, sys_rst, reg_wr, reg_rd, txn_valid, txn_is_io, gate_on, fwd_hit, irq;
  logic [ADDR_W-1:0] reg_addr;
  word_t             reg_wdata, reg_rdata, txn_addr, d, v, io_v, mem_v, up_v;
  ev_vec_t           fire, fl;
  logic              pe, pen, cs, cr, ur, em, sen, pr;  // Partner pulses and gates
  logic [31:0]       seed = 32'h0000_003f;               // Fixed seed, repeatable run
  int                err_count = 0;
  int                n_compared = 0;
  word_t             b[8] = '{32'h00013000, 32'h00012fff, 32'h00025fff, 32'h00026000,
                              32'h10000000, 32'h0fffffff, 32'h400fffff, 32'h40100000};
  bridge_secondary_window_regs dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .parity_err_seen(pe), .parity_err_resp_enable(pen), .cpl_abort_sent(cs), .cpl_abort_rcvd(cr),
    .unsup_req_rcvd(ur), .err_msg_sent(em), .system_error_report_enable(sen), .poisoned_rcvd(pr),
    .txn_valid, .txn_is_io, .txn_addr, .fwd_hit, .irq);
  packet_side_model psm (.fire, .gate_on, .parity_err_seen(pe), .parity_err_resp_enable(pen),
    .cpl_abort_sent(cs), .cpl_abort_rcvd(cr), .unsup_req_rcvd(ur), .err_msg_sent(em),
    .system_error_report_enable(sen), .poisoned_rcvd(pr));
  // ============================================================
  // Helpers
  // ============================================================
  function automatic word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Status word from written window nibbles and flags; event order matches bits 31:27 and 24
  function automatic word_t st_exp(input word_t w, input ev_vec_t f);
    return {f[5:1], 2'b00, f[0], 8'h00, w[15:12], 4'h1, w[7:4], 4'h1};
  endfunction
  // Inclusive window test from the bench's own copy of the settings
  function automatic logic exp_hit(input logic io, input word_t a);
    if (io) begin
      return a >= {up_v[15:0], io_v[7:4], 12'h000} && a <= {up_v[31:16], io_v[15:12], 12'hfff};
    end
    return a >= {mem_v[15:4], 20'h00000} && a <= {mem_v[31:20], 20'hfffff};
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input word_t w);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [ADDR_W-1:0] a, output word_t r);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 r = reg_rdata;
  endtask
  task automatic fire_ev(input int i);
    @(posedge clk_sys);
    fire <= ev_vec_t'(1 << i);
    @(posedge clk_sys);
    fire <= EV_ZERO;
  endtask
  task automatic probe(input logic io, input word_t a);
    @(posedge clk_sys);
    txn_valid <= 1'b1;
    txn_is_io <= io;
    txn_addr  <= a;
    @(posedge clk_sys);
    txn_valid <= 1'b0;
    #1 `CHK(fwd_hit, exp_hit(io, a))
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ============================================================
  // Clock and watchdog
  // ============================================================
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // A hang is cut short and counted
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    $display("BAD %0t timeout", $time);
    results();
  end
  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    {sys_rst, reg_wr, reg_rd, txn_valid, txn_is_io, gate_on} = 6'h20;
    {reg_addr, reg_wdata, txn_addr, io_v, mem_v, up_v} = '0;
    fire = EV_ZERO;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(BUS_LAT_OFS, d);  `CHK(d, 32'h0000_0000)
    rd(IO_STAT_OFS, d);  `CHK(d, st_exp(io_v, EV_ZERO))
    rd(MEM_WIN_OFS, d);  `CHK(d, 32'h0000_0000)
    rd(IO_UPPER_OFS, d); `CHK(d, 32'h0000_0000)
    $display("test reset done");
    // All ones first, then random words
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 32'hffff_ffff : rnd();
      wr(BUS_LAT_OFS, v);  rd(BUS_LAT_OFS, d);  `CHK(d, 32'h0000_0000)
      io_v = v;
      wr(IO_STAT_OFS, v);  rd(IO_STAT_OFS, d);  `CHK(d, st_exp(io_v, EV_ZERO))
      wr(MEM_WIN_OFS, v);  rd(MEM_WIN_OFS, d);  `CHK(d, v & 32'hfff0_fff0)
      wr(IO_UPPER_OFS, v); rd(IO_UPPER_OFS, d); `CHK(d, v)
      rd(8'h3c, d); `CHK(d, 32'h0000_0000)
    end
    $display("test registers done");
    // Gates low: parity and error message must not set
    fire_ev(EV_PARITY);
    fire_ev(EV_SYS_ERR);
    rd(IO_STAT_OFS, d); `CHK(d, st_exp(io_v, EV_ZERO))
    rd(IRQ_STAT_OFS, d);
    gate_on <= 1'b1;
    wr(IRQ_MASK_OFS, 32'h0000_0020);
    fl = EV_ZERO;
    for (int i = 0; i < EV_W; i++) begin
      fire_ev(i);
      fl[i] = 1'b1;
      rd(IO_STAT_OFS, d); `CHK(d, st_exp(io_v, fl))
    end
    `CHK(irq, 1'b1)
    rd(IRQ_STAT_OFS, d); `CHK(d, 32'h0000_003f)
    `CHK(irq, 1'b0)
    // Masked event leaves the line low but is still recorded
    fire_ev(EV_PARITY);
    #1 `CHK(irq, 1'b0)
    rd(IRQ_STAT_OFS, d); `CHK(d, 32'h0000_0001)
    // Write ones to the status half, nibbles kept: clearable flags go, read-only flags stay
    wr(IO_STAT_OFS, {16'hffff, io_v[15:0]});
    rd(IO_STAT_OFS, d); `CHK(d, st_exp(io_v, 6'h0e))
    $display("test events done");
    io_v  = 32'h0000_5030;
    up_v  = 32'h0002_0001;
    mem_v = 32'h4000_1000;
    wr(IO_STAT_OFS, io_v);
    wr(IO_UPPER_OFS, up_v);
    wr(MEM_WIN_OFS, mem_v);
    for (int j = 0; j < 8; j++) probe(j < 4, b[j]);
    for (int j = 0; j < 24; j++) begin
      v = rnd();
      probe(v[0], b[v[3:1]] ^ {28'h0, v[7:4]});
    end
    // Base above limit never forwards
    mem_v = 32'h1000_4000;
    wr(MEM_WIN_OFS, mem_v);
    probe(1'b0, 32'h2000_0000);
    $display("test window done");
    results();
  end
endmodule
